// File: src/gpio_expander_pkg.sv
package gpio_expander_pkg;

   // Eight-bit target address 0x6E, held here as the seven-bit form plus write bit zero.
   localparam logic [6:0] TARGET_ADDR = 7'h37;
   // Register indices.
   localparam logic [7:0] IDX_CONFIG = 8'h01;
   localparam logic [7:0] IDX_DIR = 8'h20;
   localparam logic [7:0] IDX_OUT = 8'h21;
   localparam logic [7:0] IDX_LEVEL = 8'h22;
   // Power-on values.
   localparam logic [7:0] RST_CONFIG = 8'h08;
   localparam logic [7:0] RST_DIR = 8'h08;
   localparam logic [7:0] RST_OUT = 8'h08;
   // Configuration field positions.
   localparam int CFG_INIT_BIT = 7;
   localparam int CFG_RSTOUT_EN_BIT = 5;
   localparam int CFG_AUTO_PD_BIT = 1;
   localparam int CFG_FORCE_PD_BIT = 0;
   // Idle time before auto power-down, in microseconds, and the clock period in nanoseconds.
   localparam int IDLE_PD_US = 20000;
   localparam int CLK_PERIOD_NS = 100;
   localparam int IDLE_PD_CYCLES = (IDLE_PD_US * 1000) / CLK_PERIOD_NS;

endpackage : gpio_expander_pkg

// File: src/reg_access_if.sv
`timescale 1ns/1ps
// Register access strobes between the serial target and the register file.
interface reg_access_if;
   logic [7:0] index;  // Selected register index.
   logic [7:0] wdata;  // Byte written by the host.
   logic wr_stb;       // One-cycle write strobe.
   logic rd_stb;       // One-cycle pulse when a read byte is fetched.
   logic [7:0] rdata;  // Byte returned for the current index.
   modport target (output index, output wdata, output wr_stb, output rd_stb, input rdata);
   modport regs (input index, input wdata, input wr_stb, input rd_stb, output rdata);
endinterface : reg_access_if

// File: src/i2c_target.sv
`timescale 1ns/1ps
// Oversampled serial target: finds bus edges on the system clock and moves bytes.
module i2c_target
   import gpio_expander_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_o,
   reg_access_if.target ra
);

   typedef enum {ST_IDLE, ST_ADDR, ST_ACK, ST_INDEX, ST_WDATA, ST_RDATA, ST_RACK, ST_IGNORE} tgt_state_t;

   logic [1:0] scl_s_q;  // Two-stage synchroniser for the bus clock.
   logic [1:0] sda_s_q;  // Two-stage synchroniser for the bus data.
   logic scl_q;          // Previous synchronised clock level.
   logic sda_q;          // Previous synchronised data level.
   tgt_state_t state_q;
   tgt_state_t after_ack_q;  // State entered once the acknowledge bit ends.
   logic [7:0] shift_q;
   logic [3:0] bitcnt_q;
   logic rw_q;            // Read bit of the address byte.
   logic have_index_q;    // An index byte was taken in this write phase.

   wire scl = scl_s_q[1];
   wire sda = sda_s_q[1];
   wire scl_rise = scl & ~scl_q;
   wire scl_fall = ~scl & scl_q;
   wire start_c = scl & scl_q & sda_q & ~sda;
   wire stop_c = scl & scl_q & ~sda_q & sda;

   // Synchronisers; only the second stage is looked at by logic.
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_s_q <= {scl_s_q[0], scl_i};
         sda_s_q <= {sda_s_q[0], sda_i};
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   // Protocol sequencer: address, index, then one data byte each way.
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_q <= ST_IDLE;
         after_ack_q <= ST_IDLE;
         shift_q <= 8'h00;
         bitcnt_q <= 4'h0;
         rw_q <= 1'b0;
         have_index_q <= 1'b0;
         sda_oe_o <= 1'b0;
         ra.index <= 8'h00;
         ra.wdata <= 8'h00;
         ra.wr_stb <= 1'b0;
         ra.rd_stb <= 1'b0;
      end
      else
      begin
         ra.wr_stb <= 1'b0;
         ra.rd_stb <= 1'b0;
         if (start_c)
         begin
            // A repeated start keeps the index so a read can follow.
            state_q <= ST_ADDR;
            bitcnt_q <= 4'h0;
            sda_oe_o <= 1'b0;
         end
         else if (stop_c)
         begin
            state_q <= ST_IDLE;
            sda_oe_o <= 1'b0;
         end
         else
         begin
            case (state_q)
               ST_ADDR, ST_INDEX, ST_WDATA:
               begin
                  if (scl_rise)
                  begin
                     shift_q <= {shift_q[6:0], sda};
                     bitcnt_q <= bitcnt_q + 4'h1;
                  end
                  else if (scl_fall && bitcnt_q == 4'h8)
                  begin
                     bitcnt_q <= 4'h0;
                     state_q <= ST_ACK;
                     sda_oe_o <= 1'b1;
                     if (state_q == ST_ADDR)
                     begin
                        if (shift_q[7:1] != TARGET_ADDR)
                        begin
                           sda_oe_o <= 1'b0;
                           state_q <= ST_IGNORE;
                        end
                        rw_q <= shift_q[0];
                        have_index_q <= 1'b0;
                        after_ack_q <= shift_q[0] ? ST_RDATA : ST_INDEX;
                     end
                     else if (state_q == ST_INDEX)
                     begin
                        ra.index <= shift_q;
                        have_index_q <= 1'b1;
                        after_ack_q <= ST_WDATA;
                     end
                     else
                     begin
                        ra.wdata <= shift_q;
                        ra.wr_stb <= have_index_q;
                        after_ack_q <= ST_IGNORE;
                     end
                  end
               end
               ST_ACK:
               begin
                  if (scl_fall)
                  begin
                     state_q <= after_ack_q;
                     sda_oe_o <= 1'b0;
                     if (after_ack_q == ST_RDATA)
                     begin
                        // Load the read byte; open-drain pulls low for zero bits.
                        shift_q <= ra.rdata;
                        ra.rd_stb <= 1'b1;
                        sda_oe_o <= ~ra.rdata[7];
                        bitcnt_q <= 4'h1;
                     end
                  end
               end
               ST_RDATA:
               begin
                  if (scl_fall)
                  begin
                     if (bitcnt_q == 4'h8)
                     begin
                        sda_oe_o <= 1'b0;
                        state_q <= ST_RACK;
                     end
                     else
                     begin
                        sda_oe_o <= ~shift_q[7 - bitcnt_q[2:0]];
                        bitcnt_q <= bitcnt_q + 4'h1;
                     end
                  end
               end
               ST_RACK:
               begin
                  // Only one byte per read is served; later bytes release the line.
                  if (scl_fall)
                  begin
                     state_q <= ST_IGNORE;
                  end
               end
               default:
               begin
                  sda_oe_o <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule : i2c_target

// File: src/i2c_gpio_expander_8bit.sv
// Contract
// - Answer only at bus address 0x6E.
// - Registers reachable only through serial interface.
// - Config bit 7 resets all registers.
// - Config bit 5 enables watchdog reset output.
// - Auto power-down wakes on pin change, access.
// - Forced bit clears by write or pin change.
// - Direction register: 1 output, 0 input.
// - Output register holds driven pin values.
// - Index 22h reads present pin levels.
`timescale 1ns/1ps
// Eight-pin expander: register file, pin logic and power control behind the serial target.
module i2c_gpio_expander_8bit
   import gpio_expander_pkg::*;
#(
   // Idle time before auto power-down in system clock cycles, and the pin count.
   parameter int IDLE_CYCLES = IDLE_PD_CYCLES,
   parameter int PINS = 8
)
(
   // System clock and reset, serial bus, pins, watchdog and power status.
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_oe_o,
   input wire logic [PINS-1:0] pin_i,
   output logic [PINS-1:0] pin_o,
   output logic [PINS-1:0] pin_oe_o,
   input wire logic watchdog_expired_i,
   output logic watchdog_reset_output_n_o,
   output logic powered_down_o
);

   // Index, data and strobes from the serial target; read data goes back the same way.
   reg_access_if ra ();

   // Host-visible registers; they stay eight bits wide whatever the pin count.
   logic [7:0] config_and_power_control_q;  // Configuration and power register.
   logic [7:0] pin_direction_control_q;     // Per-pin direction.
   logic [7:0] pin_output_value_q;          // Per-pin output value.
   // Pin sampling chain; the pins are asynchronous to the system clock.
   logic [PINS-1:0] pin_s1_q;               // Pin synchroniser, first stage.
   logic [PINS-1:0] pin_level_q;            // Pin synchroniser, second stage.
   logic [PINS-1:0] pin_prev_q;             // Level one cycle ago, for change detection.
   // Power management state.
   logic [31:0] idle_cnt_q;                 // Cycles since the last activity.
   logic auto_pd_q;                         // Asleep by idle timeout.
   // Present pin levels, padded to a register byte for the read path.
   logic [7:0] level_byte;

   // Any synchronised pin that moved since the previous cycle.
   wire pin_change = |(pin_level_q ^ pin_prev_q);
   // A completed register write or read counts as activity.
   // Traffic for another target, or a bare index byte, does not keep the part awake.
   wire access = ra.wr_stb | ra.rd_stb;
   // Write aimed at the configuration register.
   wire wr_cfg = ra.wr_stb && ra.index == IDX_CONFIG;

   // The serial target is the only path into the registers.
   // Power-down never gates it, since it must see the access that wakes the part.
   i2c_target u_target
   (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_oe_o(sda_oe_o),
      .ra(ra)
   );

   // Pin levels pass two flip-flops before use.
   // A third flop keeps the previous sample for the change detector.
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         // Reset to the low level; the first samples may report one harmless change.
         pin_s1_q <= '0;
         pin_level_q <= '0;
         pin_prev_q <= '0;
      end
      else
      begin
         // Shift the chain; the first stage feeds nothing but the second.
         pin_s1_q <= pin_i;
         pin_level_q <= pin_s1_q;
         pin_prev_q <= pin_level_q;
      end
   end

   // Pin counts below eight are padded into the register byte.
   always_comb
   begin
      // Bits above the pin count read as zero.
      level_byte = 8'h00;
      level_byte[PINS-1:0] = pin_level_q;
   end

   // Configuration register; the init bit self-clears since it resets everything.
   // Only host writes and the pin-change clear of the forced bit touch it.
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         // Power-on value: both power-down modes off and the reset output disabled.
         config_and_power_control_q <= RST_CONFIG;
      end
      else if (wr_cfg && ra.wdata[CFG_INIT_BIT])
      begin
         // Init drops every other bit of the same write.
         config_and_power_control_q <= RST_CONFIG;
      end
      else if (wr_cfg)
      begin
         // A host write wins over a pin change in the same cycle.
         config_and_power_control_q <= ra.wdata;
      end
      else if (pin_change)
      begin
         // A pin change clears the forced power-down bit.
         config_and_power_control_q[CFG_FORCE_PD_BIT] <= 1'b0;
      end
   end

   // Direction and output registers, both returned to power-on values by init.
   // Init is decoded here too rather than through a shared reset net, keeping one driver per register.
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         // Power-on values; one pin starts as an output driving high.
         pin_direction_control_q <= RST_DIR;
         pin_output_value_q <= RST_OUT;
      end
      else if (wr_cfg && ra.wdata[CFG_INIT_BIT])
      begin
         pin_direction_control_q <= RST_DIR;
         pin_output_value_q <= RST_OUT;
      end
      else if (ra.wr_stb && ra.index == IDX_DIR)
      begin
         // Direction changes reach the pins one cycle later through the output flops.
         pin_direction_control_q <= ra.wdata;
      end
      else if (ra.wr_stb && ra.index == IDX_OUT)
      begin
         // The value is held even for input pins and shows once they turn to outputs.
         pin_output_value_q <= ra.wdata;
      end
   end

   // Read multiplexer; unknown indices read as zero.
   // The target takes this as it loads a read byte, so it must be valid in that cycle.
   always_comb
   begin
      case (ra.index)
         IDX_CONFIG: ra.rdata = config_and_power_control_q;
         IDX_DIR: ra.rdata = pin_direction_control_q;
         IDX_OUT: ra.rdata = pin_output_value_q;
         // Pin levels are a snapshot taken one to two cycles behind the pins.
         IDX_LEVEL: ra.rdata = level_byte;
         default: ra.rdata = 8'h00;
      endcase
   end

   // Idle counter and auto power-down; any access or pin change wakes the part.
   // The 32-bit counter leaves ample room above the default idle count.
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         idle_cnt_q <= 32'h0;
         auto_pd_q <= 1'b0;
      end
      else if (access || pin_change || !config_and_power_control_q[CFG_AUTO_PD_BIT])
      begin
         // Activity, a pin change or a disabled mode all restart the idle time.
         idle_cnt_q <= 32'h0;
         auto_pd_q <= 1'b0;
      end
      else if (idle_cnt_q >= 32'(IDLE_CYCLES - 1))
      begin
         // The count holds at its end so the state is kept until the next wake event.
         auto_pd_q <= 1'b1;
      end
      else
      begin
         // Still idle: keep counting.
         idle_cnt_q <= idle_cnt_q + 32'h1;
      end
   end

   // Outputs; the serial target keeps running while asleep so it can wake the part.
   // Every output is registered so the pins never see decode glitches.
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         // Pins released and the reset output idle while in reset.
         pin_o <= '0;
         pin_oe_o <= '0;
         watchdog_reset_output_n_o <= 1'b1;
         powered_down_o <= 1'b0;
      end
      else
      begin
         // Input pins carry a low value so nothing leaks out while their enable is off.
         pin_o <= pin_output_value_q[PINS-1:0] & pin_direction_control_q[PINS-1:0];
         // The enable follows the direction register bit for bit.
         pin_oe_o <= pin_direction_control_q[PINS-1:0];
         // Active low; the expiry is passed on only while the enable bit is set.
         watchdog_reset_output_n_o <= ~(watchdog_expired_i & config_and_power_control_q[CFG_RSTOUT_EN_BIT]);
         // Reports the state only; the bus logic keeps running so a host access can wake the part.
         powered_down_o <= auto_pd_q | config_and_power_control_q[CFG_FORCE_PD_BIT];
      end
   end

endmodule : i2c_gpio_expander_8bit

// File: sim/i2c_gpio_expander_8bit_assertions.sv
`timescale 1ns/1ps
// Port-level checks on the expander; it sees only the top module's ports.
module i2c_gpio_expander_8bit_checker
   import gpio_expander_pkg::*;
#(
   parameter int IDLE_CYCLES = IDLE_PD_CYCLES,
   parameter int PINS = 8
)
(
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_oe_o,
   input wire logic [PINS-1:0] pin_i,
   input wire logic [PINS-1:0] pin_o,
   input wire logic [PINS-1:0] pin_oe_o,
   input wire logic watchdog_expired_i,
   input wire logic watchdog_reset_output_n_o,
   input wire logic powered_down_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   logic [5:0] quiet_q; // Cycles since the bus clock last moved, saturating.
   // Pin output and enable changes must trace back to recent bus traffic.
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         quiet_q <= 6'h00;
      else if ($changed(scl_i))
         quiet_q <= 6'h00;
      else if (quiet_q != 6'h3F)
         quiet_q <= quiet_q + 6'h01;
   end
   undriven_input_a: assert property ((pin_o & ~pin_oe_o) == '0)
      else $error("input pin driven");
   wdt_release_a: assert property (!watchdog_expired_i |=> watchdog_reset_output_n_o)
      else $error("reset output low without expiry");
   wdt_cause_a: assert property ($fell(watchdog_reset_output_n_o) |-> $past(watchdog_expired_i))
      else $error("reset output fell without cause");
   pd_wake_a: assert property (powered_down_o && $changed(pin_i) |-> ##[1:6] !powered_down_o)
      else $error("pin change did not wake");
   sda_hold_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
      else $error("data moved while bus clock high");
   ack_when_low_a: assert property ($rose(sda_oe_o) |-> !$past(scl_i))
      else $error("data pulled low during clock high");
   reset_values_a: assert property ($fell(rst_i) |-> ##[1:3] pin_oe_o == RST_DIR[PINS-1:0])
      else $error("direction not at power-on value");
   pin_update_a: assert property ($changed({pin_o, pin_oe_o}) |-> quiet_q < 6'h28)
      else $error("pins changed without bus access");
endmodule : i2c_gpio_expander_8bit_checker

bind i2c_gpio_expander_8bit i2c_gpio_expander_8bit_checker #(.IDLE_CYCLES(IDLE_CYCLES), .PINS(PINS)) u_checker (
   .mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_oe_o(sda_oe_o), .pin_i(pin_i),
   .pin_o(pin_o), .pin_oe_o(pin_oe_o), .watchdog_expired_i(watchdog_expired_i),
   .watchdog_reset_output_n_o(watchdog_reset_output_n_o), .powered_down_o(powered_down_o));

// File: sim/i2c_host_model.sv
`timescale 1ns/1ps
// Bus host: bit-bangs an 800 ns bus clock and only ever pulls the data line low.
module i2c_host_model
   import gpio_expander_pkg::*;
(
   input wire logic mclk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_oe_o
);
   // The bus clock stands high between frames.
   initial
   begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   task automatic q();
      repeat (2) @(posedge mclk_i);
   endtask : q
   // Data changes only while the clock is low; the wire is sampled mid-high.
   task automatic bit_io(input logic b, output logic r);
      sda_oe_o <= ~b;
      q();
      scl_o <= 1'b1;
      q();
      r = sda_i;
      q();
      scl_o <= 1'b0;
      q();
   endtask : bit_io
   // Also serves as repeated start, since it first releases the data line.
   task automatic start();
      sda_oe_o <= 1'b0;
      q();
      scl_o <= 1'b1;
      q();
      sda_oe_o <= 1'b1;
      q();
      scl_o <= 1'b0;
      q();
   endtask : start
   // Byte out MSB first; the ninth bit is released, so it is an ack slot or our NACK.
   task automatic xfer(input logic [7:0] b, output logic [7:0] r, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], r[i]);
      bit_io(1'b1, a);
      ack = ~a;
   endtask : xfer
   task automatic access(input logic [6:0] adr, input logic rd, input logic [7:0] idx, input logic [7:0] wd,
      output logic [7:0] rdat, output logic ack);
      logic [7:0] r;
      logic a1, a2, a3, nk;
      start();
      xfer({adr, 1'b0}, r, a1);
      xfer(idx, r, a2);
      if (rd)
      begin
         start();
         xfer({adr, 1'b1}, r, a3);
         xfer(8'hFF, rdat, nk);
      end
      else
         xfer(wd, r, a3);
      sda_oe_o <= 1'b1;
      q();
      scl_o <= 1'b1;
      q();
      sda_oe_o <= 1'b0;
      q();
      ack = a1 & a2 & a3;
   endtask : access
endmodule : i2c_host_model

// File: sim/i2c_gpio_expander_8bit_tb_top.sv
`timescale 1ns/1ps
// Drives the expander through the host model and judges pins and registers.
module i2c_gpio_expander_8bit_tb_top;
   import gpio_expander_pkg::*;
   logic mclk_i, rst_i, scl, host_oe, dut_oe, sda, wd_exp, wd_n, pd, ack;
   logic [7:0] ext, pin_in, pin_out, pin_oe, rd;
   int fail_count = 0;
   int n_compared = 0;
   // Data wire has a pull-up; an input pin shows the outside level.
   assign sda = ~(host_oe | dut_oe);
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
   initial
   begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   // A short idle count keeps the auto power-down runs brief, yet outlasts the rest of a read transfer after its read strobe.
   i2c_gpio_expander_8bit #(.IDLE_CYCLES(150)) u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
      .sda_oe_o(dut_oe), .pin_i(pin_in), .pin_o(pin_out), .pin_oe_o(pin_oe), .watchdog_expired_i(wd_exp),
      .watchdog_reset_output_n_o(wd_n), .powered_down_o(pd));
   i2c_host_model u_host (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   task automatic miss(input string m);
      fail_count++;
      $display("unexpected at %0t: %s", $time, m);
   endtask : miss
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string m);
      n_compared++;
      if (g !== e)
         miss(m);
   endtask : chk_byte
   task automatic chk_bit(input logic g, input logic e, input string m);
      n_compared++;
      if (g !== e)
         miss(m);
   endtask : chk_bit
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      u_host.access(TARGET_ADDR, 1'b0, i, d, rd, ack);
      chk_bit(ack, 1'b1, "write not acknowledged");
      repeat (4) @(posedge mclk_i);
   endtask : wr
   task automatic rchk(input logic [7:0] i, input logic [7:0] e);
      u_host.access(TARGET_ADDR, 1'b1, i, 8'h00, rd, ack);
      chk_bit(ack, 1'b1, "read not acknowledged");
      chk_byte(rd, e, "register read");
   endtask : rchk
   // Bounded wait for the power-down flag; running out ends the run.
   task automatic wait_pd(input logic e);
      int n;
      n = 0;
      while (pd !== e && n < 400)
      begin
         @(posedge mclk_i);
         n++;
      end
      if (n == 400)
      begin
         miss("power-down wait timed out");
         give_verdict();
      end
   endtask : wait_pd
   task automatic t_basic();
      chk_byte(pin_oe, RST_DIR, "direction reset");
      chk_byte(pin_out, RST_OUT & RST_DIR, "output reset");
      rchk(IDX_CONFIG, RST_CONFIG);
      rchk(IDX_OUT, RST_OUT);
      rchk(8'h30, 8'h00);
      u_host.access(TARGET_ADDR ^ 7'h01, 1'b0, IDX_DIR, 8'hFF, rd, ack);
      chk_bit(ack, 1'b0, "foreign address answered");
      rchk(IDX_DIR, RST_DIR);
      $display("basic test done");
   endtask : t_basic
   task automatic t_pins();
      wr(IDX_DIR, 8'hF0);
      wr(IDX_OUT, 8'hAA);
      chk_byte(pin_oe, 8'hF0, "pin enables");
      chk_byte(pin_out, 8'hA0, "driven pins");
      ext <= 8'h5C;
      rchk(IDX_OUT, 8'hAA);
      rchk(IDX_LEVEL, 8'hAC);
      wr(IDX_CONFIG, 8'h80);
      rchk(IDX_CONFIG, RST_CONFIG);
      rchk(IDX_DIR, RST_DIR);
      rchk(IDX_OUT, RST_OUT);
      $display("pin test done");
   endtask : t_pins
   task automatic t_wdt();
      wd_exp <= 1'b1;
      repeat (4) @(posedge mclk_i);
      chk_bit(wd_n, 1'b1, "reset out while disabled");
      wr(IDX_CONFIG, 8'h28);
      chk_bit(wd_n, 1'b0, "reset out not asserted");
      wd_exp <= 1'b0;
      repeat (3) @(posedge mclk_i);
      chk_bit(wd_n, 1'b1, "reset out stuck");
      wr(IDX_CONFIG, RST_CONFIG);
      $display("watchdog test done");
   endtask : t_wdt
   task automatic t_power();
      repeat (200) @(posedge mclk_i);
      chk_bit(pd, 1'b0, "auto power-down while disabled");
      wr(IDX_CONFIG, 8'h0A);
      wait_pd(1'b1);
      ext <= ext ^ 8'h01;
      wait_pd(1'b0);
      wait_pd(1'b1);
      rchk(IDX_CONFIG, 8'h0A);
      chk_bit(pd, 1'b0, "asleep after access");
      wr(IDX_CONFIG, 8'h09);
      chk_bit(pd, 1'b1, "forced power-down");
      wr(IDX_CONFIG, RST_CONFIG);
      chk_bit(pd, 1'b0, "forced bit not cleared");
      wr(IDX_CONFIG, 8'h09);
      ext <= ext ^ 8'h02;
      wait_pd(1'b0);
      rchk(IDX_CONFIG, RST_CONFIG);
      $display("power test done");
   endtask : t_power
   initial
   begin
      rst_i = 1'b1;
      ext = 8'h00;
      wd_exp = 1'b0;
      repeat (6) @(posedge mclk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge mclk_i);
      t_basic();
      t_pins();
      t_wdt();
      t_power();
      give_verdict();
   end
endmodule : i2c_gpio_expander_8bit_tb_top
